// File: include/sld_frame_if.sv
// Purpose: Carries decoded serial frames between the shifter and the registers.
// Assumes: Single clock domain on core_clk_i.
// Notes: valid is a one-cycle pulse; rdata is sampled at the next frame start.
`timescale 1ns/1ps
`default_nettype none
interface sld_frame_if;
  logic valid;
  logic wr;
  logic [6:0] addr;
  logic [19:0] wdata;
  logic [19:0] rdata;
  modport spi (output valid, output wr, output addr, output wdata, input rdata);
  modport regs (input valid, input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// File: include/sld_pkg.sv
// Purpose: Shared constants for the squib low-level diagnostic register bank.
// Assumes: 32-bit serial frames, 7-bit register addresses, 20-bit register data.
// Notes: Register field positions are bit indices within the register data word; frame positions index the 32-bit frame.
package sld_pkg;
  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_SYS_STATE = 7'h04;
  localparam logic [6:0] ADDR_STATUS = 7'h37;
  localparam logic [6:0] ADDR_REQUEST = 7'h38;
  localparam logic [6:0] ADDR_ADC_BASE = 7'h3a;
  localparam int ADC_SLOTS = 4;

  // ----------------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam int FRM_WR = 31;
  localparam int FRM_ADDR_LSB = 24;
  localparam int DATA_W = 20;
  localparam logic [5:0] FRAME_BITS_C = 6'h20;

  // ----------------------------------------------------------------------
  // Request register fields and codes
  // ----------------------------------------------------------------------
  localparam int REQ_LEVEL = 15;
  localparam int REQ_SOURCE_CURRENT_GENERATOR_RANGE = 14;
  localparam int REQ_PD_OFF = 13;
  localparam int REQ_SRC_LSB = 11;
  localparam int REQ_SINK = 10;
  localparam int REQ_MON_LSB = 8;
  localparam int REQ_RES_LSB = 4;
  localparam int REQ_LEAK_LSB = 0;
  localparam logic [15:0] REQ_RST = 16'h2000;
  localparam logic [1:0] SRC_ON = 2'h1;
  localparam logic [1:0] MON_NONE = 2'h0;
  localparam logic [1:0] MON_HS = 2'h1;
  localparam logic [1:0] MON_LS = 2'h2;
  localparam logic [1:0] MON_LS_PD = 2'h3;

  // ----------------------------------------------------------------------
  // Status and read-back fields
  // ----------------------------------------------------------------------
  localparam int ST_EXT = 19;
  localparam int ST_RES_LSB = 8;
  localparam int ST_LOOP = 7;
  localparam int ST_STG = 6;
  localparam int ST_STB = 5;
  localparam int ST_HS = 4;
  localparam int ST_LEAK_LSB = 0;
  localparam logic [19:0] STATUS_RST = 20'h00000;
  localparam int SYS_STATE_LSB = 8;
  localparam logic [2:0] STATE_INIT = 3'h0;
  localparam logic [2:0] STATE_DIAG = 3'h1;

  typedef enum logic {
    ADC_IDLE = 1'b0,
    ADC_BUSY = 1'b1
  } sld_adc_e;
endpackage

// File: logic/sld_diag_regs.sv
// Purpose: Low-level squib loop diagnostic registers for four deployment channels.
// Assumes: Monitor flags are asynchronous pins; ADC and system state share core_clk_i.
// Notes: Analog controls follow the request register one cycle after it changes.
`timescale 1ns/1ps
`default_nettype none
module sld_diag_regs (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  input wire logic [2:0] sys_state_i,
  input wire logic short_to_ground_flag_i,
  input wire logic short_to_battery_flag_i,
  input wire logic loop_short_i,
  output logic adc_req_o,
  output logic [6:0] adc_request_address_o,
  input wire logic adc_done_i,
  input wire logic [9:0] adc_result_i,
  output logic [3:0] source_current_generator_en_o,
  output logic source_current_40ma_o,
  output logic [3:0] sink_current_generator_en_o,
  output logic [3:0] pulldown_en_o,
  output logic [3:0] monitor_high_side_squib_pin_o,
  output logic [3:0] monitor_low_side_squib_pin_o
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Codes above 3 select no channel, so a bad code cannot drive two loops.
  function automatic logic [3:0] chan_onehot(input logic [3:0] code);
    logic [3:0] oh;
    oh = 4'h0;
    if (code[3:2] == 2'h0) begin
      oh[code[1:0]] = 1'b1;
    end
    return oh;
  endfunction

  // Returns {hit, slot index} for an ADC control register address.
  function automatic logic [2:0] adc_slot(input logic [6:0] addr);
    logic [6:0] off;
    off = addr - sld_pkg::ADDR_ADC_BASE;
    return {(addr >= sld_pkg::ADDR_ADC_BASE) && (off < 7'(sld_pkg::ADC_SLOTS)), off[1:0]};
  endfunction

  function automatic logic [1:0] first_set(input logic [3:0] v);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------------
  // Serial front end
  // ----------------------------------------------------------------------
  sld_frame_if frm ();

  sld_spi_slave u_spi (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .mosi_i(mosi_i),
    .miso_o(miso_o),
    .miso_oe_n_o(miso_oe_n_o),
    .frm(frm.spi)
  );

  logic wr_hit;
  logic rd_hit;
  logic [2:0] wr_slot;
  assign wr_hit = frm.valid && frm.wr;
  assign rd_hit = frm.valid && !frm.wr;
  assign wr_slot = adc_slot(frm.addr);

  // ----------------------------------------------------------------------
  // Request register
  // ----------------------------------------------------------------------
  logic [15:0] req_q;
  logic low_level;
  logic [3:0] res_oh;
  logic [3:0] leak_oh;
  logic [1:0] mon_sel;
  logic [1:0] src_sel;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      req_q <= sld_pkg::REQ_RST;
    end else if (wr_hit && frm.addr == sld_pkg::ADDR_REQUEST &&
                 sys_state_i != sld_pkg::STATE_INIT) begin
      req_q <= frm.wdata[15:0];
    end
  end

  // A set request bit 15 hands set-up to the device's own sequencer, not kept here.
  assign low_level = !req_q[sld_pkg::REQ_LEVEL];
  // Both channel fields are honoured: bits 7:4 steer source and sink, bits 3:0 monitors and pull-downs.
  assign res_oh = chan_onehot(req_q[sld_pkg::REQ_RES_LSB +: 4]);
  assign leak_oh = chan_onehot(req_q[sld_pkg::REQ_LEAK_LSB +: 4]);
  assign mon_sel = req_q[sld_pkg::REQ_MON_LSB +: 2];
  assign src_sel = req_q[sld_pkg::REQ_SRC_LSB +: 2];

  // ----------------------------------------------------------------------
  // Analog set-up controls
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      source_current_generator_en_o <= 4'h0;
      source_current_40ma_o <= 1'b0;
      sink_current_generator_en_o <= 4'h0;
      monitor_high_side_squib_pin_o <= 4'h0;
      monitor_low_side_squib_pin_o <= 4'h0;
    end else begin
      source_current_generator_en_o <= (low_level && src_sel == sld_pkg::SRC_ON) ?
                                       res_oh : 4'h0;
      source_current_40ma_o <= low_level && !req_q[sld_pkg::REQ_SOURCE_CURRENT_GENERATOR_RANGE];
      sink_current_generator_en_o <= (low_level && req_q[sld_pkg::REQ_SINK]) ?
                                     res_oh : 4'h0;
      monitor_high_side_squib_pin_o <= (low_level && mon_sel == sld_pkg::MON_HS) ?
                                       leak_oh : 4'h0;
      monitor_low_side_squib_pin_o <= (low_level && mon_sel[1]) ? leak_oh : 4'h0;
    end
  end

  // The 1 mA pull-downs keep idle loops defined; off on the monitored loop for MON_HS and MON_LS
  // so the monitor sees only that loop's leakage current; MON_LS_PD keeps all four on.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pulldown_en_o <= 4'h0;
    end else if (!low_level || req_q[sld_pkg::REQ_PD_OFF]) begin
      pulldown_en_o <= 4'h0;
    end else if (mon_sel == sld_pkg::MON_NONE || mon_sel == sld_pkg::MON_LS_PD) begin
      pulldown_en_o <= 4'hf;
    end else begin
      pulldown_en_o <= ~leak_oh;
    end
  end

  // ----------------------------------------------------------------------
  // Monitor flags and status register
  // ----------------------------------------------------------------------
  logic [2:0] flag_meta_q;
  logic [2:0] flag_sync_q;
  logic [19:0] status_q;
  logic mon_on;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      flag_meta_q <= 3'h0;
      flag_sync_q <= 3'h0;
    end else begin
      flag_meta_q <= {loop_short_i, short_to_ground_flag_i, short_to_battery_flag_i};
      flag_sync_q <= flag_meta_q;
    end
  end

  assign mon_on = low_level && mon_sel != sld_pkg::MON_NONE;

  // Flags are live: they show what the monitor sees for the current set-up.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      status_q <= sld_pkg::STATUS_RST;
    end else begin
      status_q <= 20'h0;
      status_q[sld_pkg::ST_RES_LSB +: 4] <= req_q[sld_pkg::REQ_RES_LSB +: 4];
      status_q[sld_pkg::ST_LEAK_LSB +: 4] <= req_q[sld_pkg::REQ_LEAK_LSB +: 4];
      status_q[sld_pkg::ST_LOOP] <= mon_on && flag_sync_q[2];
      status_q[sld_pkg::ST_STG] <= mon_on && flag_sync_q[1];
      status_q[sld_pkg::ST_STB] <= mon_on && flag_sync_q[0];
      status_q[sld_pkg::ST_HS] <= low_level && mon_sel == sld_pkg::MON_HS;
    end
  end

  // ----------------------------------------------------------------------
  // ADC control slots
  // ----------------------------------------------------------------------
  logic [6:0] slot_addr_q [sld_pkg::ADC_SLOTS];
  logic [9:0] slot_res_q [sld_pkg::ADC_SLOTS];
  logic [3:0] pend_q;
  logic [3:0] done_q;
  logic [1:0] cur_q;
  sld_pkg::sld_adc_e adc_st_q;
  logic grant;
  logic [1:0] pick;
  logic fin;

  assign grant = adc_st_q == sld_pkg::ADC_IDLE && pend_q != 4'h0;
  assign pick = first_set(pend_q);
  assign fin = adc_st_q == sld_pkg::ADC_BUSY && adc_done_i;

  // A new address clears done; a result landing the same cycle still sets it.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pend_q <= 4'h0;
      done_q <= 4'h0;
      for (int i = 0; i < sld_pkg::ADC_SLOTS; i++) begin
        slot_addr_q[i] <= 7'h0;
        slot_res_q[i] <= 10'h0;
      end
    end else begin
      if (grant) begin
        pend_q[pick] <= 1'b0;
      end
      if (wr_hit && wr_slot[2]) begin
        slot_addr_q[wr_slot[1:0]] <= frm.wdata[6:0];
        pend_q[wr_slot[1:0]] <= 1'b1;
        done_q[wr_slot[1:0]] <= 1'b0;
      end
      if (fin) begin
        slot_res_q[cur_q] <= adc_result_i;
        done_q[cur_q] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      adc_st_q <= sld_pkg::ADC_IDLE;
      adc_req_o <= 1'b0;
      adc_request_address_o <= 7'h0;
      cur_q <= 2'h0;
    end else begin
      adc_req_o <= 1'b0;
      case (adc_st_q)
        sld_pkg::ADC_IDLE: begin
          if (grant) begin
            adc_req_o <= 1'b1;
            adc_request_address_o <= slot_addr_q[pick];
            cur_q <= pick;
            adc_st_q <= sld_pkg::ADC_BUSY;
          end
        end
        sld_pkg::ADC_BUSY: begin
          if (adc_done_i) begin
            adc_st_q <= sld_pkg::ADC_IDLE;
          end
        end
        default: adc_st_q <= sld_pkg::ADC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read answers
  // ----------------------------------------------------------------------
  logic [19:0] rdata_q;
  logic [2:0] rd_slot;
  assign rd_slot = adc_slot(frm.addr);
  assign frm.rdata = rdata_q;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 20'h0;
    end else if (rd_hit) begin
      if (frm.addr == sld_pkg::ADDR_STATUS) begin
        rdata_q <= status_q;
      end else if (frm.addr == sld_pkg::ADDR_SYS_STATE) begin
        rdata_q <= 20'h0;
        rdata_q[sld_pkg::SYS_STATE_LSB +: 3] <= sys_state_i;
      end else if (rd_slot[2]) begin
        rdata_q <= {done_q[rd_slot[1:0]], 2'h0, slot_addr_q[rd_slot[1:0]],
                    slot_res_q[rd_slot[1:0]]};
      end else begin
        rdata_q <= 20'h0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_slot_write;
    wr_hit && wr_slot[2] && adc_st_q == sld_pkg::ADC_IDLE && pend_q == 4'h0;
  endsequence
  sequence s_adc_issue;
    ##2 adc_req_o ##1 !adc_req_o;
  endsequence

  property p_init_block;
    wr_hit && frm.addr == sld_pkg::ADDR_REQUEST && sys_state_i == sld_pkg::STATE_INIT
      |=> $stable(req_q);
  endproperty
  a_init_block: assert property (p_init_block) else $error("request taken in init");

  property p_high_level_idle;
    !low_level |=> source_current_generator_en_o == 4'h0 && pulldown_en_o == 4'h0;
  endproperty
  a_high_level_idle: assert property (p_high_level_idle) else $error("set-up in high level");

  property p_src_range;
    low_level && !req_q[sld_pkg::REQ_SOURCE_CURRENT_GENERATOR_RANGE] |=> source_current_40ma_o;
  endproperty
  a_src_range: assert property (p_src_range) else $error("40 mA not selected");

  property p_pd_all_off;
    req_q[sld_pkg::REQ_PD_OFF] ##1 req_q[sld_pkg::REQ_PD_OFF] |-> pulldown_en_o == 4'h0;
  endproperty
  a_pd_all_off: assert property (p_pd_all_off) else $error("pull-down left on");

  property p_pd_except;
    low_level && !req_q[sld_pkg::REQ_PD_OFF] && mon_sel[0] != mon_sel[1]
      |=> pulldown_en_o == ~$past(leak_oh);
  endproperty
  a_pd_except: assert property (p_pd_except) else $error("pull-down pattern wrong");

  property p_src_off;
    src_sel != sld_pkg::SRC_ON |=> source_current_generator_en_o == 4'h0;
  endproperty
  a_src_off: assert property (p_src_off) else $error("source on when off");

  property p_sink;
    low_level |=> sink_current_generator_en_o ==
      ($past(req_q[sld_pkg::REQ_SINK]) ? $past(res_oh) : 4'h0);
  endproperty
  a_sink: assert property (p_sink) else $error("sink enable wrong");

  property p_mon_ls;
    low_level && mon_sel == sld_pkg::MON_LS |=> monitor_low_side_squib_pin_o == $past(leak_oh)
      && monitor_high_side_squib_pin_o == 4'h0;
  endproperty
  a_mon_ls: assert property (p_mon_ls) else $error("low-side monitor wrong");

  property p_mon_hs;
    low_level && mon_sel == sld_pkg::MON_HS |=> monitor_high_side_squib_pin_o == $past(leak_oh);
  endproperty
  a_mon_hs: assert property (p_mon_hs) else $error("high-side monitor wrong");

  property p_ext_low;
    low_level |=> !status_q[sld_pkg::ST_EXT] && status_q[sld_pkg::ST_HS] == $past(mon_sel[0]
      && !mon_sel[1]);
  endproperty
  a_ext_low: assert property (p_ext_low) else $error("status mode bits wrong");

  property p_stg;
    mon_on && flag_sync_q[1] |=> status_q[sld_pkg::ST_STG];
  endproperty
  a_stg: assert property (p_stg) else $error("ground short not shown");

  property p_stb;
    !mon_on |=> !status_q[sld_pkg::ST_STB] && !status_q[sld_pkg::ST_LOOP];
  endproperty
  a_stb: assert property (p_stb) else $error("flag without monitor");

  property p_adc_issue;
    s_slot_write |-> s_adc_issue;
  endproperty
  a_adc_issue: assert property (p_adc_issue) else $error("conversion not issued");
endmodule
`default_nettype wire

// File: logic/sld_spi_slave.sv
// Purpose: Oversampled serial slave that turns 32-bit frames into register accesses.
// Assumes: Mode 0 serial clock well below a quarter of core_clk_i.
// Notes: A read answer goes out during the following frame.
`timescale 1ns/1ps
`default_nettype none
module sld_spi_slave (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  sld_frame_if.spi frm
);
  // ----------------------------------------------------------------------
  // Pin synchronisers, order {sclk, cs_n, mosi}
  // ----------------------------------------------------------------------
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] prev_q;
  logic [31:0] rx_q;
  logic [31:0] tx_q;
  logic [5:0] cnt_q;
  logic [6:0] last_addr_q;
  logic rise, fall, start, stop;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      meta_q <= 3'h2;
      sync_q <= 3'h2;
      prev_q <= 3'h2;
    end else begin
      meta_q <= {sclk_i, cs_n_i, mosi_i};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise = sync_q[2] & ~prev_q[2] & ~sync_q[1];
  assign fall = ~sync_q[2] & prev_q[2] & ~sync_q[1];
  assign start = ~sync_q[1] & prev_q[1];
  assign stop = sync_q[1] & ~prev_q[1];

  // ----------------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_q <= 32'h0;
      cnt_q <= 6'h0;
    end else if (start) begin
      cnt_q <= 6'h0;
    end else if (rise) begin
      rx_q <= {rx_q[30:0], sync_q[0]};
      // Saturate so that an overlong frame is refused, not wrapped.
      if (cnt_q != 6'h3f) begin
        cnt_q <= cnt_q + 6'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      frm.valid <= 1'b0;
      frm.wr <= 1'b0;
      frm.addr <= 7'h0;
      frm.wdata <= 20'h0;
      last_addr_q <= 7'h0;
    end else begin
      frm.valid <= stop && (cnt_q == sld_pkg::FRAME_BITS_C);
      if (stop && (cnt_q == sld_pkg::FRAME_BITS_C)) begin
        frm.wr <= rx_q[sld_pkg::FRM_WR];
        frm.addr <= rx_q[sld_pkg::FRM_ADDR_LSB +: 7];
        frm.wdata <= rx_q[sld_pkg::DATA_W-1:0];
        last_addr_q <= rx_q[sld_pkg::FRM_ADDR_LSB +: 7];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmit side: echo of the last address and the answer data
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_q <= 32'h0;
      miso_o <= 1'b0;
      miso_oe_n_o <= 1'b1;
    end else begin
      miso_oe_n_o <= sync_q[1];
      if (start) begin
        tx_q <= {1'b0, last_addr_q, 4'h0, frm.rdata};
        miso_o <= 1'b0;
      end else if (fall) begin
        tx_q <= {tx_q[30:0], 1'b0};
        miso_o <= tx_q[30];
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/sld_diag_regs_test.sv
// Purpose: Self-checking bench for the squib diagnostic register bank.
// Assumes: Read answers arrive in the frame after the request.
// Notes: The bench also plays the converter and the monitor comparators.
`timescale 1ns/1ps
`default_nettype none
module sld_diag_regs_test;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] sys_state = 3'h0;
  logic [2:0] flg = 3'h0;
  logic adc_done = 1'b0;
  logic [9:0] adc_res = 10'h000;
  logic [3:0] adc_cnt = 4'h0;
  logic [6:0] adc_addr = 7'h7f;
  logic [7:0] rnd = 8'h1a;
  logic sclk, cs_n, mosi, miso, miso_oe_n, adc_req, src40;
  logic [6:0] adc_ra;
  logic [3:0] src_en, sink_en, pd_en, mon_hs, mon_ls;
  logic [31:0] rx;
  logic [15:0] q;
  // The last two set-ups reach high-level mode, the 10 mA range and a monitor left open.
  logic [15:0] tbl [8] = '{16'h2900, 16'h2600, 16'h0100, 16'h0200, 16'h1900, 16'h0300,
    16'h8900, 16'h4c00};
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // The released data line floats high through a pull-up.
  wire miso_w = miso_oe_n ? 1'b1 : miso;
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  sld_host_model sld_host_model_i (.clk_i(core_clk_i), .miso_i(miso_w), .sclk_o(sclk),
    .cs_n_o(cs_n), .mosi_o(mosi));
  sld_diag_regs sld_diag_regs_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_n_o(miso_oe_n),
    .sys_state_i(sys_state), .short_to_ground_flag_i(flg[1]),
    .short_to_battery_flag_i(flg[0]), .loop_short_i(flg[2]), .adc_req_o(adc_req),
    .adc_request_address_o(adc_ra), .adc_done_i(adc_done), .adc_result_i(adc_res),
    .source_current_generator_en_o(src_en), .source_current_40ma_o(src40),
    .sink_current_generator_en_o(sink_en), .pulldown_en_o(pd_en),
    .monitor_high_side_squib_pin_o(mon_hs), .monitor_low_side_squib_pin_o(mon_ls));
  // ----------------------------------------------------------------------
  // Converter model and helpers
  // ----------------------------------------------------------------------
  always @(negedge core_clk_i) begin
    adc_done <= 1'b0;
    if (adc_req) begin
      adc_addr <= adc_ra;
      adc_cnt <= 4'h5;
    end else if (adc_cnt != 4'h0) begin
      adc_cnt <= adc_cnt - 4'h1;
      adc_done <= adc_cnt == 4'h1;
    end
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      end_sim();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [3:0] oh(input logic [3:0] c);
    return (c < 4) ? 4'h1 << c : 4'h0;
  endfunction
  function automatic logic [20:0] ctl(input logic [15:0] r);
    logic [3:0] l;
    l = oh(r[3:0]);
    // A high-level request leaves set-up to the device's own sequencer, so all stays off.
    return r[15] ? 21'h0 : {(r[12:11] == 2'h1) ? oh(r[7:4]) : 4'h0, ~r[14],
      r[10] ? oh(r[7:4]) : 4'h0,
      r[13] ? 4'h0 : ((r[9:8] == 2'h1 || r[9:8] == 2'h2) ? ~l : 4'hf),
      (r[9:8] == 2'h1) ? l : 4'h0, r[9] ? l : 4'h0};
  endfunction
  function automatic logic [19:0] st(input logic [15:0] r, input logic [2:0] f);
    return {8'h00, r[7:4], f & {3{r[9:8] != 2'h0 && !r[15]}}, r[9:8] == 2'h1 && !r[15],
      r[3:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cc(input logic [15:0] r, input logic [20:0] k);
    chk({11'h0, {src_en, src40, sink_en, pd_en, mon_hs, mon_ls} & k}, {11'h0, ctl(r) & k});
  endtask
  task automatic wr(input logic [6:0] a, input logic [19:0] d);
    sld_host_model_i.xfer({1'b1, a, 4'h0, d}, rx);
  endtask
  task automatic rd(input logic [6:0] a, input logic [19:0] e);
    sld_host_model_i.xfer({1'b0, a, 24'h0}, rx);
    sld_host_model_i.xfer({1'b0, sld_pkg::ADDR_SYS_STATE, 24'h0}, rx);
    chk(rx, {1'b0, a, 4'h0, e});
  endtask
  task automatic end_sim();
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    cc(sld_pkg::REQ_RST, 21'h1effff);
    wr(sld_pkg::ADDR_REQUEST, 20'h00911);
    cc(sld_pkg::REQ_RST, 21'h1effff);
    sys_state = sld_pkg::STATE_DIAG;
    rd(sld_pkg::ADDR_SYS_STATE, 20'h00100);
    rd(sld_pkg::ADDR_REQUEST, 20'h00000);
    rd(7'h10, 20'h00000);
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 8; s++) begin
        rnd = lfsr(rnd);
        q = tbl[s] | {8'h00, c[3:0], c[3:0]};
        flg = (s == 0) ? 3'h1 : (s == 1) ? 3'h2 : rnd[2:0];
        wr(sld_pkg::ADDR_REQUEST, {4'h0, q});
        cc(q, 21'h1fffff);
        rd(sld_pkg::ADDR_STATUS, st(q, flg));
      end
    end
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      adc_res = {rnd, 2'h1};
      wr(sld_pkg::ADDR_ADC_BASE + 7'(k), {13'h0, 7'h46 + 7'(k)});
      chk({25'h0, adc_addr}, {25'h0, 7'h46 + 7'(k)});
      rd(sld_pkg::ADDR_ADC_BASE + 7'(k), {1'b1, 2'h0, 7'h46 + 7'(k), adc_res});
    end
    end_sim();
  end
endmodule
`default_nettype wire

// File: sim/sld_host_model.sv
// Purpose: Serial controller model that issues one 32-bit frame per call.
// Assumes: Mode 0, six core cycles per half bit, clock idle low.
// Notes: The data line is inverted after each frame so a stale bit cannot pass.
`timescale 1ns/1ps
`default_nettype none
module sld_host_model (
  input wire logic clk_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    cs_n_o = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      hw(6);
      sclk_o = 1'b0;
      mosi_o = tx[i];
      hw(6);
      sclk_o = 1'b1;
      rx[i] = miso_i;
    end
    hw(6);
    sclk_o = 1'b0;
    hw(6);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    hw(12);
  endtask
endmodule
`default_nettype wire
